// >>> include/rtcr_defs.svh
// Register offsets, field positions and limits of the calendar and alarm register slice.
// Notes on behaviour
// - BCD month: tens 0-1, ones 0-9
// - Binary month: one byte, 1 to 12
// - BCD year: tens and ones digits 0-9
// - Binary year: one byte, 0 to 99
// - BCD epoch: tens and ones digits 0-9
// - Binary epoch: one byte, 0 to 99
// - Counts survive reset, writable only unlocked
// - Alarm set points survive reset, always writable
// - BCD alarm seconds: tens 0-5, ones 0-9
// - Binary alarm seconds: one byte, 0 to 59
// - BCD alarm minutes: tens 0-5, ones 0-9
// - Binary alarm minutes: one byte, 0 to 59
// - Encoding select picks BCD or binary for month, year and epoch counting; alarm set points are stored as written
// - Unlock halts counting and opens count writes
`ifndef RTCR_DEFS_SVH
`define RTCR_DEFS_SVH
`define RTCR_ADDR_MONTH 8'he5
`define RTCR_ADDR_YEAR 8'he6
`define RTCR_ADDR_EPOCH 8'he7
`define RTCR_ADDR_WAKE_SECONDS_ONES 8'he8
`define RTCR_ADDR_WAKE_MINUTES_ONES 8'he9
`define RTCR_NUM_REGS 5
`define RTCR_IDX_MONTH 3'h0
`define RTCR_IDX_YEAR 3'h1
`define RTCR_IDX_EPOCH 3'h2
`define RTCR_IDX_WAKE_SECONDS_ONES 3'h3
`define RTCR_IDX_WAKE_MINUTES_ONES 3'h4
`define RTCR_MONTH_FIRST 8'h01
`define RTCR_MONTH_LAST_BIN 8'h0c
`define RTCR_MONTH_LAST_BCD 8'h12
`define RTCR_YEAR_LAST_BIN 8'h63
`define RTCR_YEAR_LAST_BCD 8'h99
`define RTCR_SETPT_LAST_BIN 8'h3b
`define RTCR_SETPT_LAST_BCD 8'h59
`define RTCR_TENS_MSB 7
`define RTCR_TENS_LSB 4
`define RTCR_ONES_MSB 3
`define RTCR_ONES_LSB 0
`endif

// >>> include/rtcr_pkg.sv
// Types shared by the calendar and alarm register slice.
package rtcr_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rtcr_io_req_t;
  typedef struct packed {
    logic [7:0] rdata;
    logic hit;
  } rtcr_io_rsp_t;
  typedef enum logic {RTCR_ENC_BIN, RTCR_ENC_BCD} rtcr_enc_t;
endpackage

// >>> rtl/rtcr_reg_store.sv
// Five-byte register store with a registered read port and no reset, so contents survive reset.
`timescale 1ns/100ps
`default_nettype none
`include "rtcr_defs.svh"
module rtcr_reg_store
(
  // Clock
  input wire logic clk_i,
  // Write port
  input wire logic [`RTCR_NUM_REGS-1:0] we_i,
  input wire logic [7:0] wdata_i [`RTCR_NUM_REGS],
  // Read port
  input wire logic [2:0] raddr_i,
  output logic [7:0] rdata_o,
  // Whole contents for the counting logic
  output logic [7:0] q_o [`RTCR_NUM_REGS]
);
  logic [7:0] mem [`RTCR_NUM_REGS];

  genvar g;
  generate
    for (g = 0; g < `RTCR_NUM_REGS; g++)
    begin : g_ent
      always_ff @(posedge clk_i)
      begin
        if (we_i[g])
          mem[g] <= wdata_i[g];
      end
      assign q_o[g] = mem[g];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (raddr_i < 3'(`RTCR_NUM_REGS))
      rdata_o <= mem[raddr_i];
    else
      rdata_o <= 8'h00;
  end
endmodule // rtcr_reg_store
`default_nettype wire

// >>> rtl/rtcr_calendar_regs.sv
// Month, year and epoch counters with the alarm seconds and minutes set points.
`timescale 1ns/100ps
`default_nettype none
`include "rtcr_defs.svh"
module rtcr_calendar_regs
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Processor I/O cycle, same clock domain
  input wire rtcr_pkg::rtcr_io_req_t io_req_i,
  output rtcr_pkg::rtcr_io_rsp_t io_rsp_o,
  // Links to the rest of the clock
  input wire logic bcd_en_i,
  input wire logic unlock_i,
  input wire logic month_carry_i,
  // Current values for the alarm comparators
  output logic [7:0] month_o,
  output logic [7:0] year_o,
  output logic [7:0] epoch_o,
  output logic [7:0] alarm_sec_o,
  output logic [7:0] alarm_min_o
);
  logic [`RTCR_NUM_REGS-1:0] we;
  logic [`RTCR_NUM_REGS-1:0] host_we;
  logic [`RTCR_NUM_REGS-1:0] count_we;
  logic [7:0] wdata [`RTCR_NUM_REGS];
  logic [7:0] q [`RTCR_NUM_REGS];
  logic [7:0] rdata;
  logic [2:0] idx;
  logic idx_ok;
  logic rd_q;
  logic bump;
  logic month_wrap;
  logic year_wrap;
  logic [7:0] next_month;
  logic [7:0] next_year;
  logic [7:0] next_epoch;

  // Increment one byte in the active encoding; in BCD the ones digit rolls 9 to 0 with a tens carry.
  function automatic logic [7:0] inc_val(input logic [7:0] v, input logic bcd);
    logic [7:0] r;
    r = v + 8'h01;
    if (bcd && v[`RTCR_ONES_MSB:`RTCR_ONES_LSB] == 4'h9)
      r = {v[`RTCR_TENS_MSB:`RTCR_TENS_LSB] + 4'h1, 4'h0};
    return r;
  endfunction

  always_comb
  begin
    idx_ok = 1'b1;
    unique case (io_req_i.addr)
      `RTCR_ADDR_MONTH: idx = `RTCR_IDX_MONTH;
      `RTCR_ADDR_YEAR: idx = `RTCR_IDX_YEAR;
      `RTCR_ADDR_EPOCH: idx = `RTCR_IDX_EPOCH;
      `RTCR_ADDR_WAKE_SECONDS_ONES: idx = `RTCR_IDX_WAKE_SECONDS_ONES;
      `RTCR_ADDR_WAKE_MINUTES_ONES: idx = `RTCR_IDX_WAKE_MINUTES_ONES;
      default:
      begin
        idx = 3'h7;
        idx_ok = 1'b0;
      end
    endcase
  end

  assign bump = month_carry_i && !unlock_i;

  assign month_wrap = bcd_en_i ? (q[`RTCR_IDX_MONTH] == `RTCR_MONTH_LAST_BCD)
                               : (q[`RTCR_IDX_MONTH] == `RTCR_MONTH_LAST_BIN);
  assign year_wrap = bcd_en_i ? (q[`RTCR_IDX_YEAR] == `RTCR_YEAR_LAST_BCD)
                              : (q[`RTCR_IDX_YEAR] == `RTCR_YEAR_LAST_BIN);

  always_comb
  begin
    next_month = month_wrap ? `RTCR_MONTH_FIRST : inc_val(q[`RTCR_IDX_MONTH], bcd_en_i);
    next_year = year_wrap ? 8'h00 : inc_val(q[`RTCR_IDX_YEAR], bcd_en_i);
    if (q[`RTCR_IDX_EPOCH] == (bcd_en_i ? `RTCR_YEAR_LAST_BCD : `RTCR_YEAR_LAST_BIN))
      next_epoch = 8'h00;
    else
      next_epoch = inc_val(q[`RTCR_IDX_EPOCH], bcd_en_i);
  end

  always_comb
  begin
    host_we = '0;
    if (io_req_i.wr && idx_ok)
    begin
      if (idx >= `RTCR_IDX_WAKE_SECONDS_ONES)
        host_we[idx] = 1'b1;
      else if (unlock_i)
        host_we[idx] = 1'b1;
    end
  end

  always_comb
  begin
    count_we = '0;
    if (bump)
    begin
      count_we[`RTCR_IDX_MONTH] = 1'b1;
      count_we[`RTCR_IDX_YEAR] = month_wrap;
      count_we[`RTCR_IDX_EPOCH] = month_wrap && year_wrap;
    end
  end

  // Count writes need unlock and counting needs lock, so one entry never has two sources in a cycle.
  always_comb
  begin
    for (int i = 0; i < `RTCR_NUM_REGS; i++)
    begin
      we[i] = host_we[i] || count_we[i];
      wdata[i] = io_req_i.wdata;
    end
    if (count_we[`RTCR_IDX_MONTH])
      wdata[`RTCR_IDX_MONTH] = next_month;
    if (count_we[`RTCR_IDX_YEAR])
      wdata[`RTCR_IDX_YEAR] = next_year;
    if (count_we[`RTCR_IDX_EPOCH])
      wdata[`RTCR_IDX_EPOCH] = next_epoch;
  end

  rtcr_reg_store u_store
  (
    .clk_i(clk_i),
    .we_i(we),
    .wdata_i(wdata),
    .raddr_i(idx),
    .rdata_o(rdata),
    .q_o(q)
  );

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_q <= 1'b0;
    else
      rd_q <= io_req_i.rd && idx_ok;
  end

  // Read answer two cycles after the read strobe; unmapped addresses answer zero with hit low.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      io_rsp_o <= '0;
    else
      io_rsp_o <= '{rdata: (rd_q ? rdata : 8'h00), hit: rd_q};
  end

  // The store has no reset, so value outputs are cleared only until the first clock after release.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      month_o <= 8'h00;
    else
      month_o <= q[`RTCR_IDX_MONTH];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      year_o <= 8'h00;
    else
      year_o <= q[`RTCR_IDX_YEAR];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      epoch_o <= 8'h00;
    else
      epoch_o <= q[`RTCR_IDX_EPOCH];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alarm_sec_o <= 8'h00;
    else
      alarm_sec_o <= q[`RTCR_IDX_WAKE_SECONDS_ONES];
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      alarm_min_o <= 8'h00;
    else
      alarm_min_o <= q[`RTCR_IDX_WAKE_MINUTES_ONES];
  end
endmodule // rtcr_calendar_regs
`default_nettype wire

// >>> testbench/rtcr_host.sv
// Host core model driving I/O writes.
`timescale 1ns/100ps
`default_nettype none
module rtcr_host
(
  // Clock and request
  input wire logic clk_i,
  input wire rtcr_pkg::rtcr_io_rsp_t rsp_i,
  output rtcr_pkg::rtcr_io_req_t req_o
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{a, d, 1'h1, 1'h0};
    @(posedge clk_i);
    // Idle lines carry the inverse.
    req_o <= '{~a, ~d, 1'h0, 1'h0};
  endtask
  // Read answer stands one cycle, two edges after the read edge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge clk_i);
    req_o <= '{a, 8'h00, 1'h0, 1'h1};
    @(posedge clk_i);
    req_o <= '{~a, 8'hff, 1'h0, 1'h0};
    @(posedge clk_i);
    #1;
    d = rsp_i.rdata;
    h = rsp_i.hit;
  endtask
endmodule // rtcr_host
`default_nettype wire

// >>> testbench/rtcr_props.sv
// Port checker.
`timescale 1ns/100ps
`default_nettype none
module rtcr_props
(
  // Ports
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire rtcr_pkg::rtcr_io_req_t io_req_i,
  input wire rtcr_pkg::rtcr_io_rsp_t io_rsp_o,
  input wire logic [7:0] epoch_o,
  input wire logic bcd_en_i,
  input wire logic unlock_i,
  input wire logic month_carry_i,
  input wire logic [7:0] month_o,
  input wire logic [7:0] year_o,
  input wire logic [7:0] alarm_sec_o,
  input wire logic [7:0] alarm_min_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_wr(a);
    io_req_i.wr && io_req_i.addr == a;
  endsequence
  sequence s_up(b);
    month_carry_i && !unlock_i && bcd_en_i == b;
  endsequence
  property p_as; s_wr(8'he8) |-> ##2 alarm_sec_o == $past(io_req_i.wdata, 2); endproperty
  a_as: assert property (p_as) else $error("wake_seconds_ones");
  property p_am; s_wr(8'he9) |-> ##2 alarm_min_o == $past(io_req_i.wdata, 2); endproperty
  a_am: assert property (p_am) else $error("wake_minutes_ones");
  property p_mw; s_wr(8'he5) ##0 unlock_i |-> ##2 month_o == $past(io_req_i.wdata, 2); endproperty
  a_mw: assert property (p_mw) else $error("mon wr");
  property p_ml; s_wr(8'he5) ##0 !unlock_i && !month_carry_i |-> ##2 $stable(month_o); endproperty
  a_ml: assert property (p_ml) else $error("mon lock");
  property p_mi; s_up(0) ##1 month_o != 8'h0c |=> month_o == $past(month_o) + 8'h01; endproperty
  a_mi: assert property (p_mi) else $error("mon inc");
  property p_mx; s_up(0) ##1 month_o == 8'h0c |=> month_o == 8'h01; endproperty
  a_mx: assert property (p_mx) else $error("mon wrap");
  property p_bc; s_up(1) ##1 month_o == 8'h12 && year_o == 8'h99 |=> month_o == 8'h01 && year_o == 8'h00; endproperty
  a_bc: assert property (p_bc) else $error("bcd wrap");
  property p_hd; reset_n_i && !io_req_i.wr && !month_carry_i |-> ##2 $stable(month_o); endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_rd; io_req_i.rd && io_req_i.addr == 8'he9 |-> ##2 io_rsp_o.hit && io_rsp_o.rdata == $past(alarm_min_o); endproperty
  a_rd: assert property (p_rd) else $error("wake_minutes_ones read");
  property p_ep; s_up(1) ##1 month_o == 8'h12 && year_o == 8'h99 && epoch_o == 8'h99 |=> epoch_o == 8'h00; endproperty
  a_ep: assert property (p_ep) else $error("epoch wrap");
endmodule // rtcr_props
bind rtcr_calendar_regs rtcr_props u_chk (.clk_i, .reset_n_i, .io_req_i, .io_rsp_o, .epoch_o, .bcd_en_i, .unlock_i,
  .month_carry_i, .month_o, .year_o, .alarm_sec_o, .alarm_min_o);
`default_nettype wire

// >>> testbench/tb_top.sv
// Calendar slice bench.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; $display("MISMATCH %s %h %h", n, e, s); end end
module tb_top;
  logic clk_i = 1'h0, reset_n_i = 1'h0, bcd_en_i = 1'h0, unlock_i = 1'h0, month_carry_i = 1'h0;
  logic [7:0] mo, yr, ep, sec, mn;
  rtcr_pkg::rtcr_io_req_t req;
  rtcr_pkg::rtcr_io_rsp_t rsp;
  int n_errors = 0, samples_checked = 0;
  rtcr_host host (.clk_i, .rsp_i(rsp), .req_o(req));
  rtcr_calendar_regs DUT (.clk_i, .reset_n_i, .io_req_i(req), .io_rsp_o(rsp), .bcd_en_i, .unlock_i, .month_carry_i,
    .month_o(mo), .year_o(yr), .epoch_o(ep), .alarm_sec_o(sec), .alarm_min_o(mn));
  initial forever #4 clk_i = ~clk_i;
  task automatic load(input logic [7:0] m, y, e);
    @(posedge clk_i);
    unlock_i <= 1'h1;
    host.wr(8'he5, m);
    host.wr(8'he6, y);
    host.wr(8'he7, e);
    unlock_i <= 1'h0;
  endtask
  task automatic bump();
    @(posedge clk_i);
    month_carry_i <= 1'h1;
    @(posedge clk_i);
    month_carry_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask
  task automatic t_bin();
    load(8'h0c, 8'h63, 8'h05);
    host.wr(8'he5, 8'h03);
    bump();
    `CHK("mon", 8'h01, mo)
    `CHK("yr", 8'h00, yr)
    `CHK("ep", 8'h06, ep)
    @(posedge clk_i);
    unlock_i <= 1'h1;
    bump();
    `CHK("halt", 8'h01, mo)
    @(posedge clk_i);
    unlock_i <= 1'h0;
    bump();
  endtask
  task automatic t_bcd();
    @(posedge clk_i);
    bcd_en_i <= 1'h1;
    load(8'h12, 8'h99, 8'h99);
    bump();
    `CHK("ep", 8'h00, ep)
    `CHK("mon", 8'h01, mo)
    `CHK("yr", 8'h00, yr)
  endtask
  task automatic t_alarm();
    logic [7:0] d;
    logic h;
    host.wr(8'he8, 8'h45);
    host.wr(8'he9, 8'h59);
    host.wr(8'he0, 8'h00);
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    @(posedge clk_i);
    reset_n_i <= 1'h1;
    bump();
    `CHK("wake_seconds_ones", 8'h45, sec)
    `CHK("mon", 8'h02, mo)
    host.rd(8'he9, d, h);
    `CHK("wake_minutes_ones rd", 8'h59, d)
    `CHK("wake_minutes_ones hit", 1'h1, h)
    host.rd(8'he5, d, h);
    `CHK("mon rd", 8'h02, d)
    host.rd(8'he0, d, h);
    `CHK("unmapped hit", 1'h0, h)
  endtask
  task automatic close_out();
    if (n_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'h1;
    t_bin();
    t_bcd();
    t_alarm();
    close_out();
  end
endmodule // tb_top
`default_nettype wire
